// >>> hdl/rms_pkg.sv
// Constants for the receiver mode and status register bank.
// Assumes a single 200 MHz register clock shared by all users.
package rms_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] RMS_ADDR_MODE_STATUS = 8'h23;
  localparam int         RMS_DATA_W           = 8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RMS_BIT_RATE_CHOICE = 6;
  localparam int RMS_BIT_AUDIO_AUTO  = 5;
  localparam int RMS_BIT_FAST_EN     = 4;
  localparam int RMS_BIT_CABLE_COAX  = 3;
  localparam int RMS_BIT_REPEATER    = 2;

  // Strap code bit positions
  localparam int RMS_STRAP_W         = 3;
  localparam int RMS_STRAP_FAST      = 0;
  localparam int RMS_STRAP_COAX      = 1;
  localparam int RMS_STRAP_REPEATER  = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       RMS_RST_RATE_CHOICE = 1'h0;
  localparam logic       RMS_RST_AUDIO_AUTO  = 1'h1;
  localparam logic       RMS_RST_STRAP_BIT   = 1'h0;
  localparam logic [7:0] RMS_RST_RD_DATA     = 8'h00;
  localparam logic [1:0] RMS_RST_AUDIO_MODE  = 2'h0;

  // ****************************************************************
  // Back-channel rate codes and settle time
  // ****************************************************************
  typedef enum logic [2:0] {
    RMS_RATE_5M  = 3'b001,
    RMS_RATE_10M = 3'b010,
    RMS_RATE_20M = 3'b100
  } rms_rate_t;

  localparam int RMS_CLK_PERIOD_PS = 5000;
  localparam int RMS_SETTLE_NS     = 1000;
  localparam int RMS_SETTLE_CYC    = (RMS_SETTLE_NS * 1000) / RMS_CLK_PERIOD_PS;

endpackage : rms_pkg

// >>> hdl/rms_bc_rate.sv
// Back-channel rate decoder with a settle window after each change.
// Assumes fastEnable and rateChoice are registered in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module rms_bc_rate #(
  parameter int CNT_W      = 16,
  parameter int SETTLE_CYC = rms_pkg::RMS_SETTLE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       fastEnable,
  input  wire logic       rateChoice,
  output logic      [2:0] rate,
  output logic            settling
);

  rms_pkg::rms_rate_t rate_reg;
  rms_pkg::rms_rate_t rate_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic               settle_reg;
  logic               settle_next;

  always_comb begin
    if (fastEnable) begin
      rate_next = rms_pkg::RMS_RATE_20M;
    end else if (rateChoice) begin
      rate_next = rms_pkg::RMS_RATE_10M;
    end else begin
      rate_next = rms_pkg::RMS_RATE_5M;
    end
    // Link errors are expected while the new rate settles
    cnt_next    = cnt_reg;
    settle_next = settle_reg;
    if (rate_next != rate_reg) begin
      cnt_next    = CNT_W'(SETTLE_CYC - 1);
      settle_next = 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end else begin
      settle_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_reg   <= rms_pkg::RMS_RATE_5M;
      cnt_reg    <= '0;
      settle_reg <= 1'b0;
    end else begin
      rate_reg   <= rate_next;
      cnt_reg    <= cnt_next;
      settle_reg <= settle_next;
    end
  end

  assign rate     = rate_reg;
  assign settling = settle_reg;

endmodule : rms_bc_rate
`default_nettype wire

// >>> hdl/rms_mode_status.sv
// Receiver mode and status register with strap-loaded fields.
// Assumes a simple register port (address, write and read strobes) shared
// by local software and remote writes, all synchronous to mclk.
//
// Behaviour
// - Without fast enable, rate choice 0 gives 5 Mbps, 1 gives 10 Mbps.
// - Fast enable set forces 20 Mbps and ignores the rate choice bit.
// - Back channel may err briefly after rate choice or fast enable changes.
// - Audio auto-detect bit, reset 1, derives audio mode from auxiliary codes.
// - Fast enable, cable type and repeater bits load from the strap in the first cycle after reset release.
// - Cable bit 0 selects shielded twisted pair, 1 selects coax.
// - Repeater bit is read only, reports strapped repeater mode.
`timescale 1ns/100ps
`default_nettype none
module rms_mode_status #(
  parameter int SETTLE_CYC = rms_pkg::RMS_SETTLE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  // Strap code sampled after reset
  input  wire logic [2:0] strapConfigPinOne,
  // Audio mode sources
  input  wire logic       auxCodeValid,
  input  wire logic [1:0] auxAudioCode,
  input  wire logic [1:0] audioModeManual,
  // Control and status outputs
  output logic      [2:0] backChannelRate,
  output logic            backChannelSettling,
  output logic            cableCoax,
  output logic            repeaterMode,
  output logic      [1:0] audioSerialMode
);

  // ****************************************************************
  // Register fields
  // ****************************************************************
  // Strap capture runs for exactly one cycle after every reset release
  typedef enum logic [1:0] {
    RMS_ST_CAPTURE = 2'h1,
    RMS_ST_RUN     = 2'h2
  } rms_strap_st_t;

  rms_strap_st_t strapSt_reg;
  rms_strap_st_t strapSt_next;
  logic          strapPhase;
  logic       rateChoice_reg;
  logic       rateChoice_next;
  logic       audioAuto_reg;
  logic       audioAuto_next;
  logic       fastEn_reg;
  logic       fastEn_next;
  logic       coax_reg;
  logic       coax_next;
  logic       repeater_reg;
  logic       repeater_next;
  logic [1:0] audioMode_reg;
  logic [1:0] audioMode_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic [7:0] regValue;
  logic       hit;
  logic       fieldWr;

  assign hit     = (regAddr == rms_pkg::RMS_ADDR_MODE_STATUS);
  assign fieldWr = regWrEn && hit;

  // ****************************************************************
  // Readback value
  // ****************************************************************
  always_comb begin
    regValue = '0;
    regValue[rms_pkg::RMS_BIT_RATE_CHOICE] = rateChoice_reg;
    regValue[rms_pkg::RMS_BIT_AUDIO_AUTO]  = audioAuto_reg;
    regValue[rms_pkg::RMS_BIT_FAST_EN]     = fastEn_reg;
    regValue[rms_pkg::RMS_BIT_CABLE_COAX]  = coax_reg;
    regValue[rms_pkg::RMS_BIT_REPEATER]    = repeater_reg;
  end

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  always_comb begin
    strapSt_next = strapSt_reg;
    case (strapSt_reg)
      RMS_ST_CAPTURE: begin
        strapSt_next = RMS_ST_RUN;
      end
      RMS_ST_RUN: begin
        strapSt_next = RMS_ST_RUN;
      end
      default: begin
        // A corrupted code resumes normal operation rather than recapturing
        strapSt_next = RMS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strapSt_reg <= RMS_ST_CAPTURE;
    end else begin
      strapSt_reg <= strapSt_next;
    end
  end

  assign strapPhase = (strapSt_reg == RMS_ST_CAPTURE);

  // ****************************************************************
  // Mode fields
  // ****************************************************************
  always_comb begin
    rateChoice_next = rateChoice_reg;
    audioAuto_next  = audioAuto_reg;
    fastEn_next     = fastEn_reg;
    coax_next       = coax_reg;
    repeater_next   = repeater_reg;
    // Strap is caught once, in the first cycle after reset release;
    // a write in that same cycle loses to the strap for the strapped bits
    if (strapPhase) begin
      fastEn_next   = strapConfigPinOne[rms_pkg::RMS_STRAP_FAST];
      coax_next     = strapConfigPinOne[rms_pkg::RMS_STRAP_COAX];
      repeater_next = strapConfigPinOne[rms_pkg::RMS_STRAP_REPEATER];
    end
    if (fieldWr) begin
      rateChoice_next = regWrData[rms_pkg::RMS_BIT_RATE_CHOICE];
      audioAuto_next  = regWrData[rms_pkg::RMS_BIT_AUDIO_AUTO];
      if (!strapPhase) begin
        fastEn_next = regWrData[rms_pkg::RMS_BIT_FAST_EN];
        coax_next   = regWrData[rms_pkg::RMS_BIT_CABLE_COAX];
      end
      // Repeater bit and reserved bits are not writable
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rateChoice_reg <= rms_pkg::RMS_RST_RATE_CHOICE;
      audioAuto_reg  <= rms_pkg::RMS_RST_AUDIO_AUTO;
      fastEn_reg     <= rms_pkg::RMS_RST_STRAP_BIT;
      coax_reg       <= rms_pkg::RMS_RST_STRAP_BIT;
      repeater_reg   <= rms_pkg::RMS_RST_STRAP_BIT;
    end else begin
      rateChoice_reg <= rateChoice_next;
      audioAuto_reg  <= audioAuto_next;
      fastEn_reg     <= fastEn_next;
      coax_reg       <= coax_next;
      repeater_reg   <= repeater_next;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdData_next = rdData_reg;
    // Held between reads so a slow poller sees a stable value
    if (regRdEn) begin
      rdData_next = hit ? regValue : '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg <= rms_pkg::RMS_RST_RD_DATA;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ****************************************************************
  // Audio serial mode
  // ****************************************************************
  always_comb begin
    audioMode_next = audioMode_reg;
    // Between codes the last detected mode is kept, so a gap in the
    // auxiliary stream does not disturb the audio output
    if (audioAuto_reg) begin
      if (auxCodeValid) begin
        audioMode_next = auxAudioCode;
      end
    end else begin
      audioMode_next = audioModeManual;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      audioMode_reg <= rms_pkg::RMS_RST_AUDIO_MODE;
    end else begin
      audioMode_reg <= audioMode_next;
    end
  end

  // ****************************************************************
  // Back-channel rate
  // ****************************************************************
  rms_bc_rate #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_bc_rate (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .fastEnable (fastEn_reg),
    .rateChoice (rateChoice_reg),
    .rate       (backChannelRate),
    .settling   (backChannelSettling)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign regRdData       = rdData_reg;
  assign cableCoax       = coax_reg;
  assign repeaterMode    = repeater_reg;
  assign audioSerialMode = audioMode_reg;

endmodule : rms_mode_status
`default_nettype wire

// >>> dv/rms_mode_status_sva.sv
// Assertions on the mode and status register ports.
// Assumes one mclk domain and reset by sys_rst.
`timescale 1ns/100ps
`default_nettype none
module rms_mode_status_sva #(
  parameter int SETTLE_CYC = 4
) (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] strapConfigPinOne,
  input wire logic [2:0] backChannelRate,
  input wire logic       backChannelSettling,
  input wire logic       cableCoax,
  input wire logic       repeaterMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Strap loading wins over a write in the first cycle after reset
  logic      rstSeen;
  always_ff @(posedge mclk) rstSeen <= sys_rst;
  wire logic wrHit = regWrEn && regAddr == 8'h23 && !rstSeen;
  a_rate_fast: assert property (wrHit && regWrData[4] |-> ##2 backChannelRate == 3'h4)
    else $error("rate not 20M");
  a_rate_choice: assert property (wrHit && !regWrData[4] |-> ##2
    backChannelRate == ($past(regWrData[6], 2) ? 3'h2 : 3'h1)) else $error("slow rate wrong");
  a_coax_wr: assert property (wrHit |=> cableCoax == $past(regWrData[3]))
    else $error("cable type wrong");
  a_rep_ro: assert property (regWrEn && !rstSeen |=> $stable(repeaterMode))
    else $error("repeater bit written");
  a_strap_load: assert property ($fell(sys_rst) |-> ##2
    {repeaterMode, cableCoax} == $past(strapConfigPinOne[2:1], 2)) else $error("strap lost");
  a_rsvd_zero: assert property (regRdEn |=> regRdData[7] == 1'h0 && regRdData[1:0] == 2'h0)
    else $error("reserved bits set");
  a_unmapped_rd: assert property (regRdEn && regAddr != 8'h23 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_settle_on: assert property ($changed(backChannelRate) |-> backChannelSettling)
    else $error("no settle flag");
  a_settle_len: assert property ($fell(backChannelSettling) |->
    $past(backChannelSettling, SETTLE_CYC)) else $error("settle too short");
endmodule : rms_mode_status_sva
bind rms_mode_status rms_mode_status_sva #(.SETTLE_CYC(SETTLE_CYC)) rms_mode_status_sva_inst (
  .mclk, .sys_rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .strapConfigPinOne,
  .backChannelRate, .backChannelSettling, .cableCoax, .repeaterMode);
`default_nettype wire

// >>> dv/rms_remote_ser.sv
// Remote serializer model: sends audio codes in its aux data.
// Assumes the bench calls send_code; rate changes come only from the bench,
// so the remote auto-acknowledge is taken as on
`timescale 1ns/100ps
`default_nettype none
module rms_remote_ser (
  input  wire logic       mclk,
  output logic            auxCodeValid,
  output logic      [1:0] auxAudioCode
);
  initial begin
    auxCodeValid = 1'h0;
    auxAudioCode = 2'h0;
  end
  // Idle code is inverted so a stale value never looks valid
  task automatic send_code(input logic [1:0] c);
    @(posedge mclk);
    auxCodeValid <= 1'h1;
    auxAudioCode <= c;
    @(posedge mclk);
    auxCodeValid <= 1'h0;
    auxAudioCode <= ~c;
  endtask : send_code
endmodule : rms_remote_ser
`default_nettype wire

// >>> dv/receiver_mode_status_register_test.sv
// Self-checking bench for the mode and status register.
// Assumes SETTLE_CYC of 4 and aux codes from the remote model.
`timescale 1ns/100ps
`default_nettype none
module receiver_mode_status_register_test;
  logic       mclk, sys_rst, regWrEn, regRdEn, auxValid, settling, coax, rep;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [2:0] strap, rate;
  logic [1:0] auxCode, manual, audio;
  logic [7:0] wd[3] = '{8'h00, 8'h50, 8'h40};
  logic [7:0] we[3] = '{8'h01, 8'h04, 8'h02};
  int         errTotal = 0;
  int         checksDone = 0;
  rms_mode_status #(.SETTLE_CYC(4)) rms_mode_status_inst (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .strapConfigPinOne(strap), .auxCodeValid(auxValid), .auxAudioCode(auxCode),
    .audioModeManual(manual), .backChannelRate(rate), .backChannelSettling(settling),
    .cableCoax(coax), .repeaterMode(rep), .audioSerialMode(audio));
  rms_remote_ser rms_remote_ser_inst (
    .mclk(mclk), .auxCodeValid(auxValid), .auxAudioCode(auxCode));
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'h1;
    @(posedge mclk);
    regWrEn <= 1'h0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge mclk);
    regRdEn <= 1'h0;
    #1 chk("regRdData", e, regRdData);
  endtask : rc
  task automatic rst(input logic [2:0] s);
    @(posedge mclk);
    sys_rst <= 1'h1;
    strap   <= s;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask : rst
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Tests need under a hundred cycles; this leaves wide margin
  initial begin
    #20000;
    errTotal++;
    stop_test();
  end
  initial begin
    sys_rst   = 1'h1;
    regWrEn   = 1'h0;
    regRdEn   = 1'h0;
    regAddr   = 8'h23;
    regWrData = 8'h00;
    strap     = 3'h3;
    manual    = 2'h1;
    rst(3'h3);
    rc(8'h23, 8'h38);
    chk("rate", 8'h04, {5'h0, rate});
    chk("coax", 8'h01, {7'h0, coax});
    chk("rep", 8'h00, {7'h0, rep});
    $display("strap test done");
    foreach (wd[i]) begin
      wr(8'h23, wd[i]);
      tick(1);
      chk("rate", we[i], {5'h0, rate});
      chk("settle", 8'h01, {7'h0, settling});
      tick(6);
      chk("settle", 8'h00, {7'h0, settling});
    end
    $display("rate test done");
    wr(8'h23, 8'hff);
    rc(8'h23, 8'h78);
    wr(8'h24, 8'h00);
    rc(8'h23, 8'h78);
    rc(8'h24, 8'h00);
    $display("access test done");
    rms_remote_ser_inst.send_code(2'h2);
    tick(2);
    chk("audio", 8'h02, {6'h0, audio});
    wr(8'h23, 8'h58);
    tick(2);
    chk("audio", 8'h01, {6'h0, audio});
    rms_remote_ser_inst.send_code(2'h3);
    tick(2);
    chk("audio", 8'h01, {6'h0, audio});
    $display("audio test done");
    rst(3'h4);
    rc(8'h23, 8'h24);
    chk("coax", 8'h00, {7'h0, coax});
    chk("rep", 8'h01, {7'h0, rep});
    wr(8'h23, 8'h00);
    rc(8'h23, 8'h04);
    $display("repeater test done");
    stop_test();
  end
endmodule : receiver_mode_status_register_test
`default_nettype wire
